// ---- adcc_defines.vh ----
// Constants for the converter control register block.
// Assumes inclusion by bare name from the same folder.
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// Register indices; byte address is four times the index
`define ADCC_IDX_CLK_SETUP   16'hff80
`define ADCC_IDX_PIN_SEL     16'hff81
`define ADCC_IDX_START_CHAN  16'hff82
`define ADCC_IDX_RESULT_HI   16'hff83
`define ADCC_IDX_RESULT_LO   16'hff84

// Bus geometry
`define ADCC_ADDR_W          18
`define ADCC_DATA_W          32

// Field positions in the clock setup register
`define ADCC_GATE_BIT        3
`define ADCC_PSEL_HI         2
`define ADCC_PSEL_LO         0

// Field positions in the pin select register
`define ADCC_PIN_HI          7
`define ADCC_PIN_LO          4

// Field positions in the start and channel register
`define ADCC_START_BIT       7
`define ADCC_CHAN_HI         1
`define ADCC_CHAN_LO         0

// Reset values
`define ADCC_RST_GATE        1'h0
`define ADCC_RST_PSEL        3'h0
`define ADCC_RST_PIN         4'h0
`define ADCC_RST_CHAN        2'h0
`define ADCC_RST_RESULT      10'h000

// Prescaler code that picks the low-speed oscillator
`define ADCC_PSEL_LOW_SPEED  3'h7

// Bus responses
`define ADCC_RESP_OKAY       2'h0
`define ADCC_RESP_SLVERR     2'h2

`endif

// ---- adcc_prescaler.v ----
// Converter clock enable generator: divides the main clock or follows
// the low-speed oscillator pin, gated by the clock gate bit.
// Assumes the main oscillator is aclk; the low-speed pin is asynchronous.
`timescale 1ns/1ns
`include "adcc_defines.vh"

module adcc_prescaler (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       gate,
  input  wire [2:0] psel,
  input  wire       low_speed_osc_clock,
  output reg        conv_clk_tick
);

  reg       slow_meta;
  reg       slow_sync;
  reg       slow_prev;
  reg [5:0] div_count;
  wire [5:0] div_last;
  wire       slow_rise;

  // Divide by two to the power of the code, so terminal count is 2^n - 1
  assign div_last  = (6'h01 << psel) - 6'h01;
  assign slow_rise = slow_sync & ~slow_prev;

  // Pin passes two flip-flops before the edge detector looks at it
  always @(posedge aclk) begin
    if (!aresetn) begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
    end else begin
      slow_meta <= low_speed_osc_clock;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_count     <= 6'h00;
      conv_clk_tick <= 1'b0;
    end else if (!gate) begin
      div_count     <= 6'h00;
      conv_clk_tick <= 1'b0;
    end else if (psel == `ADCC_PSEL_LOW_SPEED) begin
      div_count     <= 6'h00;
      conv_clk_tick <= slow_rise;
    end else if (div_count >= div_last) begin
      div_count     <= 6'h00;
      conv_clk_tick <= 1'b1;
    end else begin
      div_count     <= div_count + 6'h01;
      conv_clk_tick <= 1'b0;
    end
  end

endmodule

// ---- adcc_regs.v ----
// Converter control and result registers behind an AXI4-Lite slave.
// Assumes the converter core runs on aclk and presents its result with
// a one-cycle valid strobe; the low-speed oscillator arrives as a pin.
`timescale 1ns/1ns
`include "adcc_defines.vh"

// Operation
// - A clock gate bit switches the converter clock on at one and off at zero, reads back and resets to zero.
// - A three-bit prescaler code picks main clock divided by 1 to 64 for codes 000 to 110 and the low-speed oscillator for 111, resetting to zero.
// - Four read-write bits, one per upper port pin, pick analog input at one or general I/O at zero, all reset to zero.
// - Writing one to the write-only start bit begins a conversion, writing zero does nothing, and the bit reads zero.
// - A two-bit read-write channel code routes analog input 0 to 3 to the converter and resets to zero.
// - The upper result register shows result bits nine down to two on its bits seven down to zero.
// - The lower result register shows result bits one and zero on its bits one and zero.
module adcc_regs (
  input  wire                    aclk,
  input  wire                    aresetn,
  // AXI4-Lite write address channel
  input  wire [`ADCC_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  // AXI4-Lite write data channel
  input  wire [`ADCC_DATA_W-1:0] s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  // AXI4-Lite write response channel
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  // AXI4-Lite read address channel
  input  wire [`ADCC_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  // AXI4-Lite read data channel
  output reg  [`ADCC_DATA_W-1:0] s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  // Converter core side
  input  wire                    low_speed_osc_clock,
  input  wire [9:0]              conv_result,
  input  wire                    conv_result_valid,
  output wire                    conv_clk_tick,
  output reg                     conv_clock_gate,
  output reg  [2:0]              prescale_sel,
  output reg  [3:0]              analog_pin_sel,
  output reg                     conversion_start,
  output reg  [1:0]              channel_sel
);

  // Write path holding registers, result store and read mux signals
  reg                    aw_held;
  reg [`ADCC_ADDR_W-1:0] aw_addr;
  reg                    w_held;
  reg [7:0]              w_byte;
  reg                    w_lane0;
  reg [9:0]              result;
  reg [7:0]              next_rbyte;
  reg                    next_rhit;
  wire                   do_write;

  // Byte address of a register index; drops the two word-offset bits
  function hit;
    input [`ADCC_ADDR_W-1:0] addr;
    input [15:0]             idx;
    begin
      hit = (addr[`ADCC_ADDR_W-1:2] == idx);
    end
  endfunction

  function mapped;
    input [`ADCC_ADDR_W-1:0] addr;
    begin
      mapped = hit(addr, `ADCC_IDX_CLK_SETUP)  |
               hit(addr, `ADCC_IDX_PIN_SEL)    |
               hit(addr, `ADCC_IDX_START_CHAN) |
               hit(addr, `ADCC_IDX_RESULT_HI)  |
               hit(addr, `ADCC_IDX_RESULT_LO);
    end
  endfunction

  // Each channel takes one beat, then waits until the response drains
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= {`ADCC_ADDR_W{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? `ADCC_RESP_OKAY
                                      : `ADCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Registers live in byte lane 0; a write without that lane changes none
  always @(posedge aclk) begin
    if (!aresetn) begin
      conv_clock_gate  <= `ADCC_RST_GATE;
      prescale_sel     <= `ADCC_RST_PSEL;
      analog_pin_sel   <= `ADCC_RST_PIN;
      channel_sel      <= `ADCC_RST_CHAN;
      conversion_start <= 1'b0;
    end else begin
      conversion_start <= 1'b0;
      if (do_write && w_lane0) begin
        if (hit(aw_addr, `ADCC_IDX_CLK_SETUP)) begin
          conv_clock_gate <= w_byte[`ADCC_GATE_BIT];
          prescale_sel    <= w_byte[`ADCC_PSEL_HI:`ADCC_PSEL_LO];
        end
        if (hit(aw_addr, `ADCC_IDX_PIN_SEL)) begin
          analog_pin_sel <= w_byte[`ADCC_PIN_HI:`ADCC_PIN_LO];
        end
        if (hit(aw_addr, `ADCC_IDX_START_CHAN)) begin
          conversion_start <= w_byte[`ADCC_START_BIT];
          channel_sel      <= w_byte[`ADCC_CHAN_HI:`ADCC_CHAN_LO];
        end
      end
    end
  end

  // Result is captured from the core; software cannot write it
  always @(posedge aclk) begin
    if (!aresetn) begin
      result <= `ADCC_RST_RESULT;
    end else if (conv_result_valid) begin
      result <= conv_result;
    end
  end

  // Read mux; unused bits and the start bit read as zero
  always @* begin
    next_rbyte = 8'h00;
    next_rhit  = mapped(s_axi_araddr);
    if (hit(s_axi_araddr, `ADCC_IDX_CLK_SETUP)) begin
      next_rbyte = {4'h0, conv_clock_gate, prescale_sel};
    end else if (hit(s_axi_araddr, `ADCC_IDX_PIN_SEL)) begin
      next_rbyte = {analog_pin_sel, 4'h0};
    end else if (hit(s_axi_araddr, `ADCC_IDX_START_CHAN)) begin
      next_rbyte = {6'h00, channel_sel};
    end else if (hit(s_axi_araddr, `ADCC_IDX_RESULT_HI)) begin
      next_rbyte = result[9:2];
    end else if (hit(s_axi_araddr, `ADCC_IDX_RESULT_LO)) begin
      next_rbyte = {6'h00, result[1:0]};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= {`ADCC_DATA_W{1'b0}};
      s_axi_rresp  <= `ADCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, next_rbyte};
      s_axi_rresp  <= next_rhit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Converter clock enable; stops cleanly when the gate bit is cleared
  adcc_prescaler u_prescaler (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .gate                (conv_clock_gate),
    .psel                (prescale_sel),
    .low_speed_osc_clock (low_speed_osc_clock),
    .conv_clk_tick       (conv_clk_tick)
  );

endmodule

// ---- adcc_regs_asserts.sv ----
// Checker for the converter register block, top ports only.
// Assumes it is bound into every adcc_regs instance.
`timescale 1ns/1ns
module adcc_regs_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        conv_clk_tick,
  input wire        conv_clock_gate,
  input wire [2:0]  prescale_sel,
  input wire        conversion_start
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_done;
    $rose(s_axi_bvalid);
  endsequence
  sequence s_slow_idle;
    (!conv_clk_tick)[*4];
  endsequence
  a_start_from_write: assert property ($rose(conversion_start) |-> s_wr_done)
    else $error("start pulse without a write");
  a_start_one_cycle: assert property (conversion_start |=> !conversion_start)
    else $error("start pulse too long");
  a_gate_off_quiet: assert property ((!conv_clock_gate)[*2] |-> !conv_clk_tick)
    else $error("tick while gate is off");
  a_div_one_tick: assert property
    ((conv_clock_gate && prescale_sel == 3'h0)[*3] |-> conv_clk_tick)
    else $error("no tick at divide by one");
  a_div_two_gap: assert property (conv_clk_tick && conv_clock_gate
    && prescale_sel == 3'h1 && $stable(prescale_sel) |=> !conv_clk_tick)
    else $error("ticks too close at divide by two");
  a_slow_gap: assert property (conv_clk_tick && prescale_sel == 3'h7
    && $stable(prescale_sel) |=> s_slow_idle)
    else $error("slow clock ticks too close");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind adcc_regs adcc_regs_asserts chk_i (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .conv_clk_tick, .conv_clock_gate,
  .prescale_sel, .conversion_start);

// ---- adcc_conv_model.sv ----
// Behavioural converter core and free-running low-speed oscillator.
// Assumes start is a one-cycle pulse on aclk; level is set by the bench.
`timescale 1ns/1ns
module adcc_conv_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       conversion_start,
  input  wire [9:0] level,
  output reg  [9:0] conv_result,
  output reg        conv_result_valid,
  output reg        low_speed_osc_clock
);
  reg [3:0] busy;
  reg [4:0] div;
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 4'h0;
      div <= 5'h00;
      low_speed_osc_clock <= 1'b0;
    end else begin
      div <= (div == 5'h13) ? 5'h00 : div + 5'h01;
      if (div == 5'h13)
        low_speed_osc_clock <= ~low_speed_osc_clock;
      if (conversion_start)
        busy <= 4'hc;
      else if (busy != 4'h0)
        busy <= busy - 4'h1;
    end
    conv_result_valid <= aresetn && busy == 4'h1;
    // Result is only meaningful with the strobe, so it churns otherwise
    conv_result <= (busy == 4'h1) ? level : ~conv_result;
  end
endmodule

// ---- adcc_regs_bench.sv ----
// Self-checking bench for the converter registers over AXI4-Lite.
// Assumes adcc_regs as DUT beside the behavioural converter core.
`timescale 1ns/1ns
`include "adcc_defines.vh"
module adcc_regs_bench;
  reg         aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  reg         s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg  [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0, rd_d;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg  [9:0]  level = 0;
  reg  [1:0]  rsp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, low_speed_osc_clock, conv_result_valid;
  wire        conv_clk_tick, conv_clock_gate, conversion_start;
  wire [1:0]  s_axi_bresp, s_axi_rresp, channel_sel;
  wire [31:0] s_axi_rdata;
  wire [9:0]  conv_result;
  wire [2:0]  prescale_sel;
  wire [3:0]  analog_pin_sel;
  integer     failures = 0, comparisons = 0, cycles = 0, starts = 0, k, n, e;
  always #2 aclk = ~aclk;
  adcc_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_speed_osc_clock,
    .conv_result, .conv_result_valid, .conv_clk_tick, .conv_clock_gate,
    .prescale_sel, .analog_pin_sel, .conversion_start, .channel_sel);
  adcc_conv_model core (.aclk, .aresetn, .conversion_start, .level,
    .conv_result, .conv_result_valid, .low_speed_osc_clock);
  task print_verdict;
    begin
      if (failures == 0 && comparisons > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== ex) begin
        failures = failures + 1;
        $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  // Ready rides with the request and drops at the edge that takes the answer
  task wr(input [15:0] i, input [31:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      forever begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_bvalid) begin
          rsp = s_axi_bresp;
          s_axi_bready <= 0;
          break;
        end
      end
    end
  endtask
  task rchk(input [15:0] i, input [31:0] ex, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      forever begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        if (s_axi_rvalid) begin
          rd_d = s_axi_rdata;
          rsp = s_axi_rresp;
          s_axi_rready <= 0;
          break;
        end
      end
      chk("rdata", ex, rd_d);
      chk("rresp", er, rsp);
    end
  endtask
  task ticks(input integer len);
    begin
      n = 0;
      repeat (len) begin
        @(posedge aclk);
        n = n + conv_clk_tick;
      end
    end
  endtask
  always @(posedge aclk) begin
    cycles = cycles + 1;
    starts = starts + conversion_start;
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    chk("outs", 0, {conv_clock_gate, prescale_sel, analog_pin_sel});
    rchk(`ADCC_IDX_CLK_SETUP, 0, `ADCC_RESP_OKAY);
    rchk(`ADCC_IDX_PIN_SEL, 0, `ADCC_RESP_OKAY);
    rchk(`ADCC_IDX_START_CHAN, 0, `ADCC_RESP_OKAY);
    for (k = 0; k < 8; k = k + 1) begin
      wr(`ADCC_IDX_CLK_SETUP, 32'hf8 | k);
      rchk(`ADCC_IDX_CLK_SETUP, 8 | k, `ADCC_RESP_OKAY);
      chk("psel", k, prescale_sel);
      chk("gate", 1, conv_clock_gate);
      ticks(128);
      e = (k == 7) ? 3 : 128 >> k;
      chk("ticks", 1, n >= e - 1 && n <= e + 1);
    end
    wr(`ADCC_IDX_CLK_SETUP, 32'h07);
    ticks(64);
    chk("gate_off", 0, n);
    wr(`ADCC_IDX_PIN_SEL, 32'hff);
    rchk(`ADCC_IDX_PIN_SEL, 32'hf0, `ADCC_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(`ADCC_IDX_PIN_SEL, 32'h05);
    s_axi_wstrb <= 4'hf;
    rchk(`ADCC_IDX_PIN_SEL, 32'hf0, `ADCC_RESP_OKAY);
    wr(`ADCC_IDX_PIN_SEL, 32'ha5);
    rchk(`ADCC_IDX_PIN_SEL, 32'ha0, `ADCC_RESP_OKAY);
    chk("pins", 4'ha, analog_pin_sel);
    for (k = 0; k < 4; k = k + 1) begin
      level <= 10'h2c3 ^ (10'h111 * k[9:0]);
      wr(`ADCC_IDX_START_CHAN, 32'hfc | k);
      rchk(`ADCC_IDX_START_CHAN, k, `ADCC_RESP_OKAY);
      chk("chan", k, channel_sel);
      n = 0;
      while (!conv_result_valid && n < 50) begin
        @(posedge aclk);
        n = n + 1;
      end
      @(posedge aclk);
      rchk(`ADCC_IDX_RESULT_HI, level[9:2], `ADCC_RESP_OKAY);
      rchk(`ADCC_IDX_RESULT_LO, level[1:0], `ADCC_RESP_OKAY);
    end
    wr(`ADCC_IDX_START_CHAN, 32'h01);
    repeat (4) @(posedge aclk);
    chk("starts", 4, starts);
    wr(16'hff85, 32'hff);
    chk("bresp", `ADCC_RESP_SLVERR, rsp);
    rchk(16'hff85, 0, `ADCC_RESP_SLVERR);
    // Mid-run reset must clear every field set above
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    chk("rst_outs", 0, {conv_clock_gate, prescale_sel, channel_sel});
    chk("rst_pins", 0, analog_pin_sel);
    rchk(`ADCC_IDX_START_CHAN, 0, `ADCC_RESP_OKAY);
    print_verdict;
  end
endmodule
